// [hub_model.sv]
// Behavioural hub: takes event bytes, may stall, answers each message with ack or nack.
// Assumes the valid/ready stream of the reporter on one clock.
`timescale 1ns/1ns
module hub_model (
    input logic clock,
    input logic resetn,
    input logic slow,
    input logic ev_valid,
    input logic [7:0] ev_data,
    input logic ev_last,
    output logic ev_ready,
    output logic hub_ack,
    output logic hub_nack
);
    logic [7:0] buf_q [0:15];
    logic [7:0] idx_q, len_q, n_msg;
    always @(posedge clock)
    begin
        hub_ack <= 1'b0;
        hub_nack <= 1'b0;
        if (!resetn)
        begin
            ev_ready <= 1'b0;
            idx_q <= 8'h00;
            len_q <= 8'h00;
            n_msg <= 8'h00;
        end
        else
        begin
            // Slow mode drops ready every other cycle.
            ev_ready <= slow ? !ev_ready : 1'b1;
            if (ev_valid && ev_ready)
            begin
                buf_q[idx_q[3:0]] <= ev_data;
                idx_q <= ev_last ? 8'h00 : idx_q + 8'h01;
                if (ev_last)
                begin
                    len_q <= idx_q + 8'h01;
                    n_msg <= n_msg + 8'h01;
                    hub_ack <= !n_msg[0];
                    hub_nack <= n_msg[0];
                end
            end
        end
    end
endmodule // hub_model

// [panel_supervision_trouble_reporter.v]
// Panel supervision, trouble LED coding, connection LED and hub event sender.
// Assumes one clock, synchronous inputs, pulse inputs one cycle wide.
//
// Summary of operation
// - Trouble LED repeats bursts of 2, 10 or 12 flashes per trouble type.
// - Only highest priority trouble shown; fewest flashes wins; LED off when none.
// - Six consecutive missed polls declare panel supervision trouble.
// - One good poll clears supervision trouble and resets the miss count.
// - Send panel-absent trouble on loss, matching restore on return.
// - Absent events carry the module account code.
// - Only absent events originate here; everything else is forwarded panel traffic.
// - Absent trouble event sent only after loss lasting over sixty seconds.
// - Each absent event has an enable; 00 suppresses, FF permits, default FF.
// - Account code all zeros or all ones raises module configuration trouble.
// - Module configuration trouble shows only on the local LED.
// - Format 03 selects Contact ID, 04 selects SIA, SIA at reset.
// - SIA ET/ER zone 001; Contact ID qualifier 1/3, code 355, zone 001.
// - Connection LED: one blink per send, two per ack or nack, on during fault.
// - Network and trouble LEDs flash together until initialization completes.
// - Failed remote programming raises configuration failure trouble.
// - 16-bit installer code, any value, required before programming.
// - Keypad may read settings but every keypad write is rejected.
// - SIA message holds account, new-event marker, area, event id, zone.
`timescale 1ns/1ns
`include "supervision_map.vh"

module panel_supervision_trouble_reporter #(
    parameter [63:0] ABSENT_CYCLES = `ABSENT_TIME_S * `CLOCK_HZ,
    parameter [63:0] FLASH_HALF_CYCLES = `FLASH_HALF_MS * `CLOCK_HZ / 64'd1000,
    parameter [63:0] BLINK_HALF_CYCLES = `BLINK_HALF_MS * `CLOCK_HZ / 64'd1000
) (
    input wire clock,
    input wire resetn,
    input wire init_done,
    input wire poll_done,
    input wire poll_ok,
    input wire prog_rd,
    input wire prog_wr,
    input wire [11:0] prog_section,
    input wire [23:0] prog_wdata,
    input wire [15:0] prog_code,
    input wire prog_fail,
    output reg prog_ack,
    output reg prog_err,
    output reg [23:0] prog_rdata,
    input wire kp_rd,
    input wire kp_wr,
    input wire [11:0] kp_section,
    output reg kp_ack,
    output reg kp_err,
    output reg [23:0] kp_rdata,
    input wire panel_ev_valid,
    input wire [7:0] panel_ev_data,
    input wire panel_ev_last,
    output wire panel_ev_ready,
    output wire ev_valid,
    output wire [7:0] ev_data,
    output wire ev_last,
    input wire ev_ready,
    input wire hub_ack,
    input wire hub_nack,
    input wire link_fault,
    output reg supervision_trouble,
    output reg cfg_fail_trouble,
    output wire module_cfg_trouble,
    output reg trouble_led,
    output reg network_led
);

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_FWD = 3'b010;
localparam [2:0] ST_INT = 3'b100;
localparam [63:0] ABSENT_LAST = ABSENT_CYCLES;
localparam [63:0] FLASH_LAST = FLASH_HALF_CYCLES - 64'd1;
localparam [63:0] BLINK_LAST = BLINK_HALF_CYCLES - 64'd1;

reg [15:0] installer_passcode_q;
reg [23:0] module_account_code_q;
reg [7:0] report_format_select_q;
reg [7:0] absent_trouble_enable_q;
reg [7:0] absent_restore_enable_q;
reg [23:0] interactive_account_code_q;
reg [2:0] miss_q;
reg [32:0] absent_cnt_q;
reg absent_sent_q;
reg trb_pend_q;
reg rst_pend_q;
reg [2:0] state_q;
reg [3:0] idx_q;
reg [3:0] last_idx_q;
reg is_restore_q;
reg is_cid_q;
reg [23:0] acct_q;
reg [7:0] char_q;
reg [31:0] flash_cnt_q;
reg [4:0] phase_q;
reg [4:0] burst_n_q;
reg init_phase_q;
reg [31:0] blink_cnt_q;
reg [3:0] blink_left_q;
reg [4:0] code_now;
reg [4:0] blink_add;
wire flash_tick;
wire blink_tick;
wire start_int;
wire send_done;

// ---------------------------------------------------------------
// Register decode
// ---------------------------------------------------------------
function [24:0] reg_read;
    input [11:0] sec;
    begin
        case (sec)
            `SEC_INSTALLER: reg_read = {9'h000, installer_passcode_q};
            `SEC_ACCOUNT: reg_read = {1'b0, module_account_code_q};
            `SEC_FORMAT: reg_read = {17'h00000, report_format_select_q};
            `SEC_ABS_TRB_EN: reg_read = {17'h00000, absent_trouble_enable_q};
            `SEC_ABS_RST_EN: reg_read = {17'h00000, absent_restore_enable_q};
            `SEC_INT_ACCOUNT: reg_read = {1'b0, interactive_account_code_q};
            default: reg_read = 25'h1000000;
        endcase
    end
endfunction

function [7:0] hex_char;
    input [3:0] n;
    begin
        if (n < 4'ha)
            hex_char = 8'h30 + {4'h0, n};
        else
            hex_char = 8'h37 + {4'h0, n};
    end
endfunction

// Character of an internally built message, account code first.
function [7:0] msg_char;
    input [3:0] i;
    input rst;
    input cid;
    input [23:0] acct;
    begin
        case (i)
            4'h0: msg_char = hex_char(acct[23:20]);
            4'h1: msg_char = hex_char(acct[19:16]);
            4'h2: msg_char = hex_char(acct[15:12]);
            4'h3: msg_char = hex_char(acct[11:8]);
            4'h4: msg_char = hex_char(acct[7:4]);
            4'h5: msg_char = hex_char(acct[3:0]);
            4'h6: msg_char = cid ? (rst ? 8'h33 : 8'h31) : 8'h4e;
            4'h7: msg_char = cid ? 8'h33 : 8'h72;
            4'h8: msg_char = cid ? 8'h35 : 8'h69;
            4'h9: msg_char = cid ? 8'h35 : 8'h30;
            4'ha: msg_char = cid ? 8'h30 : 8'h45;
            4'hb: msg_char = cid ? 8'h30 : (rst ? 8'h52 : 8'h54);
            4'hc: msg_char = cid ? 8'h31 : 8'h30;
            4'hd: msg_char = 8'h30;
            4'he: msg_char = 8'h31;
            default: msg_char = 8'h30;
        endcase
    end
endfunction

// ---------------------------------------------------------------
// Programming paths
// ---------------------------------------------------------------
wire [24:0] prog_look = reg_read(prog_section);
wire [24:0] kp_look = reg_read(kp_section);
wire code_ok = (prog_code == installer_passcode_q);
wire prog_take = prog_wr && code_ok && !prog_look[24];

always @(posedge clock)
begin
    if (!resetn)
    begin
        installer_passcode_q <= `RST_INSTALLER;
        module_account_code_q <= `RST_ACCOUNT;
        report_format_select_q <= `RST_FORMAT;
        absent_trouble_enable_q <= `RST_EVENT_EN;
        absent_restore_enable_q <= `RST_EVENT_EN;
        interactive_account_code_q <= `RST_INT_ACCOUNT;
        prog_ack <= 1'b0;
        prog_err <= 1'b0;
        prog_rdata <= 24'h000000;
        kp_ack <= 1'b0;
        kp_err <= 1'b0;
        kp_rdata <= 24'h000000;
        cfg_fail_trouble <= 1'b0;
    end
    else
    begin
        prog_ack <= prog_rd || prog_wr;
        prog_err <= (prog_rd && prog_look[24]) || (prog_wr && !prog_take);
        prog_rdata <= prog_rd ? prog_look[23:0] : 24'h000000;
        kp_ack <= kp_rd || kp_wr;
        kp_err <= kp_wr || (kp_rd && kp_look[24]);
        kp_rdata <= kp_rd ? kp_look[23:0] : 24'h000000;
        if (prog_take)
        begin
            case (prog_section)
                `SEC_INSTALLER: installer_passcode_q <= prog_wdata[15:0];
                `SEC_ACCOUNT: module_account_code_q <= prog_wdata;
                `SEC_FORMAT: report_format_select_q <= prog_wdata[7:0];
                `SEC_ABS_TRB_EN: absent_trouble_enable_q <= prog_wdata[7:0];
                `SEC_ABS_RST_EN: absent_restore_enable_q <= prog_wdata[7:0];
                `SEC_INT_ACCOUNT: interactive_account_code_q <= prog_wdata;
                default: installer_passcode_q <= installer_passcode_q;
            endcase
        end
        // A failure in the same cycle as a good write keeps the trouble raised.
        if (prog_fail)
            cfg_fail_trouble <= 1'b1;
        else if (prog_take)
            cfg_fail_trouble <= 1'b0;
    end
end

// Four-digit accounts arrive already padded, so no special case here.
assign module_cfg_trouble = (module_account_code_q == 24'h000000) ||
    (module_account_code_q == 24'hffffff);

// ---------------------------------------------------------------
// Panel supervision and absent events
// ---------------------------------------------------------------
always @(posedge clock)
begin
    if (!resetn)
    begin
        miss_q <= 3'h0;
        supervision_trouble <= 1'b0;
        absent_cnt_q <= 33'h000000000;
        absent_sent_q <= 1'b0;
        trb_pend_q <= 1'b0;
        rst_pend_q <= 1'b0;
    end
    else
    begin
        if (poll_done && poll_ok)
        begin
            miss_q <= 3'h0;
            supervision_trouble <= 1'b0;
        end
        else if (poll_done && miss_q != `MISS_LIMIT)
        begin
            miss_q <= miss_q + 3'h1;
            if (miss_q + 3'h1 == `MISS_LIMIT)
                supervision_trouble <= 1'b1;
        end
        // Loss time runs from the declaration of supervision trouble.
        if (!supervision_trouble || absent_sent_q)
            absent_cnt_q <= 33'h000000000;
        else
            absent_cnt_q <= absent_cnt_q + 33'h000000001;
        if (supervision_trouble && !absent_sent_q && absent_cnt_q == ABSENT_LAST[32:0])
        begin
            absent_sent_q <= 1'b1;
            if (absent_trouble_enable_q != `EVENT_OFF)
                trb_pend_q <= 1'b1;
        end
        else if (start_int && !is_restore_q)
            trb_pend_q <= 1'b0;
        if (poll_done && poll_ok && absent_sent_q)
        begin
            absent_sent_q <= 1'b0;
            if (absent_restore_enable_q != `EVENT_OFF)
                rst_pend_q <= 1'b1;
        end
        else if (start_int && is_restore_q)
            rst_pend_q <= 1'b0;
    end
end

// ---------------------------------------------------------------
// Hub stream: forwarded panel events or internal absent events
// ---------------------------------------------------------------
wire int_want = trb_pend_q || rst_pend_q;
wire int_rst = !trb_pend_q;
wire want_cid = (report_format_select_q == `FMT_CID);
assign start_int = (state_q == ST_INT) && (idx_q == 4'h0) && ev_ready;
assign send_done = (state_q == ST_INT) && ev_ready && (idx_q == last_idx_q);
// Module configuration trouble has no message of its own.
assign ev_valid = (state_q == ST_INT) || ((state_q == ST_FWD) && panel_ev_valid);
assign ev_data = (state_q == ST_INT) ? char_q : panel_ev_data;
assign ev_last = (state_q == ST_INT) ? (idx_q == last_idx_q) : panel_ev_last;
assign panel_ev_ready = (state_q == ST_FWD) && ev_ready;

always @(posedge clock)
begin
    if (!resetn)
    begin
        state_q <= ST_IDLE;
        idx_q <= 4'h0;
        last_idx_q <= `SIA_LAST_IDX;
        is_restore_q <= 1'b0;
        is_cid_q <= 1'b0;
        acct_q <= 24'h000000;
        char_q <= 8'h00;
    end
    else
    begin
        case (state_q)
            ST_IDLE:
            begin
                if (int_want)
                begin
                    state_q <= ST_INT;
                    idx_q <= 4'h0;
                    is_restore_q <= int_rst;
                    is_cid_q <= want_cid;
                    acct_q <= module_account_code_q;
                    last_idx_q <= want_cid ? `CID_LAST_IDX : `SIA_LAST_IDX;
                    char_q <= msg_char(4'h0, int_rst, want_cid, module_account_code_q);
                end
                else if (panel_ev_valid)
                    state_q <= ST_FWD;
            end
            ST_FWD:
            begin
                if (panel_ev_valid && ev_ready && panel_ev_last)
                    state_q <= ST_IDLE;
            end
            ST_INT:
            begin
                if (send_done)
                    state_q <= ST_IDLE;
                else if (ev_ready)
                begin
                    idx_q <= idx_q + 4'h1;
                    char_q <= msg_char(idx_q + 4'h1, is_restore_q, is_cid_q, acct_q);
                end
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end

// ---------------------------------------------------------------
// LEDs
// ---------------------------------------------------------------
assign flash_tick = (flash_cnt_q == FLASH_LAST[31:0]);
assign blink_tick = (blink_cnt_q == BLINK_LAST[31:0]);

always @*
begin
    if (supervision_trouble)
        code_now = `FLASH_SUPERVISION;
    else if (cfg_fail_trouble)
        code_now = `FLASH_CFG_FAIL;
    else if (module_cfg_trouble)
        code_now = `FLASH_MODULE_CFG;
    else
        code_now = 5'h00;
    blink_add = 5'h00;
    if (ev_valid && ev_ready && ((state_q == ST_INT) ? idx_q == 4'h0 : 1'b0))
        blink_add = 5'h02;
    if (hub_ack || hub_nack)
        blink_add = blink_add + 5'h04;
end

wire fwd_first = (state_q == ST_IDLE) && !int_want && panel_ev_valid;
wire [4:0] burst_end = {burst_n_q[3:0], 1'b0} + `FLASH_GAP_HALVES - 5'h01;
wire [4:0] blink_sum = {1'b0, blink_left_q} + blink_add + (fwd_first ? 5'h02 : 5'h00);
// Blinks queue in whole pairs of halves, so odd counts always mean dark.
wire [3:0] blink_next = (blink_sum > 5'h0e) ? 4'he : blink_sum[3:0];

always @(posedge clock)
begin
    if (!resetn)
    begin
        flash_cnt_q <= 32'h00000000;
        phase_q <= 5'h00;
        burst_n_q <= 5'h00;
        init_phase_q <= 1'b0;
        blink_cnt_q <= 32'h00000000;
        blink_left_q <= 4'h0;
        trouble_led <= 1'b0;
        network_led <= 1'b0;
    end
    else
    begin
        flash_cnt_q <= flash_tick ? 32'h00000000 : flash_cnt_q + 32'h00000001;
        blink_cnt_q <= blink_tick ? 32'h00000000 : blink_cnt_q + 32'h00000001;
        if (flash_tick)
        begin
            init_phase_q <= !init_phase_q;
            if (phase_q >= burst_end)
            begin
                phase_q <= 5'h00;
                burst_n_q <= code_now;
            end
            else
                phase_q <= phase_q + 5'h01;
        end
        if (blink_tick && blink_left_q != 4'h0)
            blink_left_q <= blink_next - 4'h1;
        else
            blink_left_q <= blink_next;
        if (!init_done)
        begin
            trouble_led <= init_phase_q;
            network_led <= init_phase_q;
        end
        else
        begin
            trouble_led <= (code_now != 5'h00) && (burst_n_q != 5'h00) &&
                (phase_q < {burst_n_q[3:0], 1'b0}) && !phase_q[0];
            network_led <= link_fault ||
                ((blink_left_q != 4'h0) && !blink_left_q[0]);
        end
    end
end

endmodule // panel_supervision_trouble_reporter

// [panel_supervision_trouble_reporter_test.sv]
// Self-checking bench for the supervision and trouble reporter with a hub model.
// Assumes short timing parameters so the absent delay takes 65 cycles.
`timescale 1ns/1ns
module panel_supervision_trouble_reporter_test;
    reg clock = 0, resetn = 0, init_done = 0, poll_done = 0, poll_ok = 0, prog_rd = 0, prog_wr = 0;
    reg [11:0] prog_section = 12'h000, kp_section = 12'h000;
    reg [23:0] prog_wdata = 24'h000000;
    reg [15:0] prog_code = 16'h0000;
    reg prog_fail = 0, kp_rd = 0, kp_wr = 0, link_fault = 0, slow = 0, pev_valid = 0, pev_last = 0;
    reg [7:0] pev_data = 8'h00;
    wire prog_ack, prog_err, kp_ack, kp_err, ev_valid, ev_last, ev_ready, hub_ack, hub_nack, panel_ev_ready;
    wire [23:0] prog_rdata, kp_rdata;
    wire [7:0] ev_data;
    wire supervision_trouble, cfg_fail_trouble, module_cfg_trouble, trouble_led, network_led;
    integer mismatches = 0, check_count = 0;
    panel_supervision_trouble_reporter #(.ABSENT_CYCLES(64'd64), .FLASH_HALF_CYCLES(64'd4),
        .BLINK_HALF_CYCLES(64'd4)) uut (.clock(clock), .resetn(resetn), .init_done(init_done),
        .poll_done(poll_done), .poll_ok(poll_ok), .prog_rd(prog_rd), .prog_wr(prog_wr),
        .prog_section(prog_section), .prog_wdata(prog_wdata), .prog_code(prog_code), .prog_fail(prog_fail),
        .prog_ack(prog_ack), .prog_err(prog_err), .prog_rdata(prog_rdata), .kp_rd(kp_rd), .kp_wr(kp_wr),
        .kp_section(kp_section), .kp_ack(kp_ack), .kp_err(kp_err), .kp_rdata(kp_rdata),
        .panel_ev_valid(pev_valid), .panel_ev_data(pev_data), .panel_ev_last(pev_last),
        .panel_ev_ready(panel_ev_ready),
        .ev_valid(ev_valid), .ev_data(ev_data), .ev_last(ev_last), .ev_ready(ev_ready), .hub_ack(hub_ack),
        .hub_nack(hub_nack), .link_fault(link_fault), .supervision_trouble(supervision_trouble),
        .cfg_fail_trouble(cfg_fail_trouble), .module_cfg_trouble(module_cfg_trouble),
        .trouble_led(trouble_led), .network_led(network_led));
    hub_model hub (.clock(clock), .resetn(resetn), .slow(slow), .ev_valid(ev_valid), .ev_data(ev_data),
        .ev_last(ev_last), .ev_ready(ev_ready), .hub_ack(hub_ack), .hub_nack(hub_nack));
    always #4 clock = ~clock;
    task conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input [23:0] got, input [23:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task prog(input wr, input [11:0] sec, input [23:0] d, input [15:0] code, input err, input [23:0] rd);
        @(posedge clock);
        #1 prog_rd = !wr; prog_wr = wr; prog_section = sec; prog_wdata = d; prog_code = code;
        @(posedge clock);
        #1 prog_rd = 0; prog_wr = 0;
        chk(prog_ack, 1);
        chk(prog_err, err);
        if (!wr) chk(prog_rdata, rd);
    endtask
    task kp(input wr, input [11:0] sec, input err, input [23:0] rd);
        @(posedge clock);
        #1 kp_rd = !wr; kp_wr = wr; kp_section = sec;
        @(posedge clock);
        #1 kp_rd = 0; kp_wr = 0;
        chk(kp_ack, 1);
        chk(kp_err, err);
        if (!wr) chk(kp_rdata, rd);
    endtask
    task poll(input ok, input integer n);
        repeat (n)
        begin
            @(posedge clock);
            #1 poll_done = 1; poll_ok = ok;
            @(posedge clock);
            #1 poll_done = 0;
        end
    endtask
    // Builds the expected text itself and waits, bounded, for the hub to log one more message.
    task msg(input [23:0] acct, input cid, input rst);
        integer k, n;
        reg [47:0] a;
        reg [119:0] s;
        reg [7:0] old;
        old = hub.n_msg;
        for (k = 0; k < 6; k = k + 1)
            a[47-8*k -: 8] = acct[23-4*k -: 4] < 10 ? 8'h30 + acct[23-4*k -: 4] : 8'h37 + acct[23-4*k -: 4];
        s = cid ? {a, rst ? "3" : "1", "355001"} : {a, "Nri0E", rst ? "R" : "T", "001"};
        n = cid ? 13 : 15;
        for (k = 0; k < 400 && hub.n_msg === old; k = k + 1)
            @(posedge clock);
        #1 chk(hub.len_q, n);
        for (k = 0; k < n; k = k + 1)
            chk(hub.buf_q[k], s[8*(n-1-k) +: 8]);
    endtask
    task fwd(input [7:0] d, input l);
        @(posedge clock);
        #1 pev_valid = 1; pev_data = d; pev_last = l;
        @(posedge clock);
        while (!panel_ev_ready) @(posedge clock);
        #1 pev_valid = 0;
    endtask
    task t_reset;
        chk(module_cfg_trouble, 1);
        chk(supervision_trouble, 0);
        prog(0, 12'h00b, 0, 0, 0, 24'h00cafe);
        prog(0, 12'h015, 0, 0, 0, 24'hffffff);
        prog(0, 12'h016, 0, 0, 0, 24'h000004);
        prog(0, 12'h017, 0, 0, 0, 24'h0000ff);
        prog(0, 12'h018, 0, 0, 0, 24'h0000ff);
        prog(0, 12'h28b, 0, 0, 0, 24'h000000);
        prog(0, 12'h100, 0, 0, 1, 24'h000000);
        repeat (20) @(posedge clock);
        #1 init_done = 1;
        $display("reset test done");
    endtask
    task t_program;
        @(posedge clock);
        #1 prog_fail = 1;
        @(posedge clock);
        #1 prog_fail = 0;
        chk(cfg_fail_trouble, 1);
        prog(1, 12'h015, 24'h1c2d3e, 16'h1234, 1, 0);
        prog(0, 12'h015, 0, 0, 0, 24'hffffff);
        prog(1, 12'h015, 24'h000000, 16'hcafe, 0, 0);
        chk(module_cfg_trouble, 1);
        prog(1, 12'h015, 24'h1c2d3e, 16'hcafe, 0, 0);
        chk(module_cfg_trouble, 0);
        chk(cfg_fail_trouble, 0);
        prog(1, 12'h28b, 24'habcdef, 16'hcafe, 0, 0);
        prog(1, 12'h00b, 24'h000000, 16'hcafe, 0, 0);
        prog(0, 12'h00b, 0, 0, 0, 24'h000000);
        kp(1, 12'h015, 1, 0);
        kp(0, 12'h015, 0, 24'h1c2d3e);
        $display("programming test done");
    endtask
    task t_supervise;
        slow = 1;
        poll(0, 5);
        poll(1, 1);
        poll(0, 5);
        chk(supervision_trouble, 0);
        poll(0, 1);
        chk(supervision_trouble, 1);
        repeat (60) @(posedge clock);
        #1 chk(ev_valid, 0);
        msg(24'h1c2d3e, 0, 0);
        poll(1, 1);
        chk(supervision_trouble, 0);
        msg(24'h1c2d3e, 0, 1);
        slow = 0;
        $display("supervision test done");
    endtask
    task t_cid;
        prog(1, 12'h016, 24'h000003, 16'h0000, 0, 0);
        prog(1, 12'h015, 24'h1234ff, 16'h0000, 0, 0);
        poll(0, 6);
        msg(24'h1234ff, 1, 0);
        poll(1, 1);
        msg(24'h1234ff, 1, 1);
        $display("contact id test done");
    endtask
    task t_forward;
        integer k;
        reg [7:0] cnt;
        cnt = hub.n_msg + 8'h01;
        fwd(8'h5a, 0);
        chk(panel_ev_ready, 1);
        fwd(8'ha5, 1);
        chk(panel_ev_ready, 0);
        chk(hub.n_msg, cnt);
        chk(hub.len_q, 2);
        chk(hub.buf_q[0], 8'h5a);
        chk(hub.buf_q[1], 8'ha5);
        for (k = 0; k < 16 && !network_led; k = k + 1)
            #8;
        chk(network_led, 1);
        repeat (80) @(posedge clock);
        #1 chk(network_led, 0);
        $display("forward test done");
    endtask
    task t_disable;
        reg [7:0] cnt;
        prog(1, 12'h016, 24'h000004, 16'h0000, 0, 0);
        prog(1, 12'h017, 24'h000000, 16'h0000, 0, 0);
        cnt = hub.n_msg;
        poll(0, 6);
        repeat (150) @(posedge clock);
        #1 chk(hub.n_msg, cnt);
        poll(1, 1);
        msg(24'h1234ff, 0, 1);
        @(posedge clock);
        #1 link_fault = 1;
        repeat (4) @(posedge clock);
        #1 chk(network_led, 1);
        link_fault = 0;
        $display("enable and fault test done");
    endtask
    initial
    begin
        repeat (10) @(posedge clock);
        #1 resetn = 1;
        t_reset;
        t_program;
        t_supervise;
        t_cid;
        t_forward;
        t_disable;
        conclude;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches = mismatches + 1;
        conclude;
    end
endmodule // panel_supervision_trouble_reporter_test

// [sup_chk.sv]
// Concurrent checks on the ports of the supervision and trouble reporter.
// Assumes one clock and the synchronous active-low reset of the design.
`timescale 1ns/1ns
module sup_chk (
    input logic clock,
    input logic resetn,
    input logic init_done,
    input logic poll_done,
    input logic poll_ok,
    input logic prog_rd,
    input logic prog_wr,
    input logic prog_fail,
    input logic prog_ack,
    input logic kp_wr,
    input logic kp_ack,
    input logic kp_err,
    input logic ev_valid,
    input logic [7:0] ev_data,
    input logic ev_ready,
    input logic link_fault,
    input logic supervision_trouble,
    input logic cfg_fail_trouble,
    input logic module_cfg_trouble,
    input logic trouble_led,
    input logic network_led
);
    logic [2:0] miss_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Misses in a row, saturating; a good poll starts the run again.
    always @(posedge clock)
    begin
        if (!resetn)
            miss_q <= 3'h0;
        else if (poll_done)
            miss_q <= poll_ok ? 3'h0 : (miss_q == 3'h7 ? 3'h7 : miss_q + 3'h1);
    end
    property p_ack; (prog_rd || prog_wr) |=> prog_ack; endproperty
    a_ack: assert property (p_ack) else $error("programming request not answered");
    property p_kp; kp_wr |=> kp_ack && kp_err; endproperty
    a_kp: assert property (p_kp) else $error("keypad write not refused");
    property p_six; poll_done && !poll_ok && miss_q == 3'h5 |=> supervision_trouble; endproperty
    a_six: assert property (p_six) else $error("sixth miss did not raise trouble");
    property p_rise; $rose(supervision_trouble) |-> $past(poll_done && !poll_ok) && miss_q == 3'h6; endproperty
    a_rise: assert property (p_rise) else $error("trouble raised without six misses");
    property p_clear; poll_done && poll_ok |=> !supervision_trouble; endproperty
    a_clear: assert property (p_clear) else $error("good poll did not clear trouble");
    property p_quiet; $rose(supervision_trouble) |-> !ev_valid [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("absent event sent too early");
    property p_fail; prog_fail |=> cfg_fail_trouble; endproperty
    a_fail: assert property (p_fail) else $error("failed programming not flagged");
    property p_off; (init_done && !supervision_trouble && !cfg_fail_trouble && !module_cfg_trouble) [*8]
        |-> !trouble_led; endproperty
    a_off: assert property (p_off) else $error("trouble led lit with no trouble");
    property p_unison; !init_done && $past(!init_done) |-> trouble_led == network_led; endproperty
    a_unison: assert property (p_unison) else $error("leds not in unison before ready");
    property p_fault; link_fault ##1 link_fault |-> network_led; endproperty
    a_fault: assert property (p_fault) else $error("network led not steady on fault");
    property p_hold; ev_valid && !ev_ready |=> ev_valid && $stable(ev_data); endproperty
    a_hold: assert property (p_hold) else $error("hub byte changed before taken");
endmodule // sup_chk
bind panel_supervision_trouble_reporter sup_chk u_chk (.clock, .resetn, .init_done, .poll_done, .poll_ok,
    .prog_rd, .prog_wr, .prog_fail, .prog_ack, .kp_wr, .kp_ack, .kp_err, .ev_valid, .ev_data, .ev_ready,
    .link_fault, .supervision_trouble, .cfg_fail_trouble, .module_cfg_trouble, .trouble_led, .network_led);

// [supervision_map.vh]
// Constants for the panel supervision and trouble reporter.
// Included by the design file; holds definitions only.
`ifndef SUPERVISION_MAP_VH
`define SUPERVISION_MAP_VH

// Programming sections.
`define SEC_INSTALLER 12'h00b
`define SEC_ACCOUNT 12'h015
`define SEC_FORMAT 12'h016
`define SEC_ABS_TRB_EN 12'h017
`define SEC_ABS_RST_EN 12'h018
`define SEC_INT_ACCOUNT 12'h28b

// Reset values.
`define RST_INSTALLER 16'hcafe
`define RST_ACCOUNT 24'hffffff
`define RST_FORMAT 8'h04
`define RST_EVENT_EN 8'hff
`define RST_INT_ACCOUNT 24'h000000

// Format codes and event enable off value.
`define FMT_CID 8'h03
`define FMT_SIA 8'h04
`define EVENT_OFF 8'h00

// Trouble flash counts and supervision.
`define FLASH_SUPERVISION 5'h02
`define FLASH_CFG_FAIL 5'h0a
`define FLASH_MODULE_CFG 5'h0c
`define FLASH_GAP_HALVES 5'h06
`define MISS_LIMIT 3'h6

// Message layout: last character index per format.
`define SIA_LAST_IDX 4'he
`define CID_LAST_IDX 4'hc

// Timing.
`define CLOCK_HZ 64'd125000000
`define ABSENT_TIME_S 64'd60
`define FLASH_HALF_MS 64'd250
`define BLINK_HALF_MS 64'd60

`endif
